/* design/ebm_pkg.sv */
// Package of constants shared by the external memory bus pin mux
package ebm_pkg;
	// Pin group, AHB address and decode widths
	localparam int DATA_W  = 32;
	localparam int ADDR_W  = 26;
	localparam int CS_W    = 8;
	localparam int SDA_W   = 13;
	localparam int BYTE_W  = 4;
	localparam int BANK_W  = 2;
	localparam int HADDR_W = 32;
	localparam int DEC_W   = 12;

	// Register map: byte address of the chip select assignment register
	localparam logic [DEC_W-1:0] CSA_OFFSET = 12'h11C;
	localparam logic [31:0] CSA_RESET = 32'h0001_0000;
	localparam logic [31:0] CSA_WMASK = 32'h0003_013A;

	// Field positions inside the assignment register
	localparam int CS1_OWNER_BIT   = 1;
	localparam int CS3_NAND_BIT    = 3;
	localparam int CS4_CARD1_BIT   = 4;
	localparam int CS5_CARD2_BIT   = 5;
	localparam int DATA_PULLUP_BIT = 8;
	localparam int MEM_VOLT_BIT    = 16;
	localparam int PAD_SLEW_BIT    = 17;

	// Chip select lines with special ownership
	localparam int CS_OWNED_IDX = 1;
	localparam int CS_NAND_IDX  = 3;
	localparam int CS_CARD1_IDX = 4;
	localparam int CS_CARD2_IDX = 5;

	// Number of data lines held by the pull-ups
	localparam int PULLUP_BITS = 16;

	// AHB transfer type: bit 1 set means NONSEQ or SEQ
	localparam int HTRANS_ACT_BIT = 1;

	// Owner of the multiplexed pins for the current cycle
	typedef enum logic [1:0] {
		EBM_OWN_IDLE,
		EBM_OWN_STATIC,
		EBM_OWN_DRAM
	} ebm_owner_t;
endpackage

/* design/ebm_cfg_if.sv */
// Interface carrying configuration from register block to pin mux
`timescale 1ns/1ps
interface ebm_cfg_if;
	logic cs1_owner_select;
	logic cs3_nand_logic_enable;
	logic cs4_card_slot1_enable;
	logic cs5_card_slot2_enable;
	logic data_pullup_disable;
	logic memory_voltage_select;
	logic pad_slew_select;

	modport regs (
		output cs1_owner_select,
		output cs3_nand_logic_enable,
		output cs4_card_slot1_enable,
		output cs5_card_slot2_enable,
		output data_pullup_disable,
		output memory_voltage_select,
		output pad_slew_select
	);
	modport mux (
		input  cs1_owner_select,
		input  cs3_nand_logic_enable,
		input  cs4_card_slot1_enable,
		input  cs5_card_slot2_enable,
		input  data_pullup_disable,
		input  memory_voltage_select,
		input  pad_slew_select
	);
endinterface

/* design/ebm_sync.sv */
// Two flip-flop synchroniser for pin inputs
`timescale 1ns/1ps
module ebm_sync #(
	parameter int           WIDTH = 1,
	parameter logic [WIDTH-1:0] INIT = '0
) (
	input  wire logic             i_clk,
	input  wire logic             i_rst_b,
	input  wire logic [WIDTH-1:0] i_async,
	output logic      [WIDTH-1:0] o_sync
);
	logic [WIDTH-1:0] meta;
	logic [WIDTH-1:0] next_meta;
	logic [WIDTH-1:0] next_sync;

	// First stage feeds only the second stage
	always_comb begin
		next_meta = i_async;
		next_sync = meta;
	end

	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			meta   <= INIT;
			o_sync <= INIT;
		end else begin
			meta   <= next_meta;
			o_sync <= next_sync;
		end
	end
endmodule

/* design/ebm_regs.sv */
// AHB-Lite slave holding the chip select assignment register
`timescale 1ns/1ps
module ebm_regs (
	input  wire logic                        i_clk,
	input  wire logic                        i_rst_b,
	input  wire logic                        i_hsel,
	input  wire logic [ebm_pkg::HADDR_W-1:0] i_haddr,
	input  wire logic [1:0]                  i_htrans,
	input  wire logic                        i_hwrite,
	input  wire logic [2:0]                  i_hsize,
	input  wire logic [31:0]                 i_hwdata,
	input  wire logic                        i_hready,
	output logic                             o_hreadyout,
	output logic                             o_hresp,
	output logic [31:0]                      o_hrdata,
	ebm_cfg_if.regs                          cfg
);
	logic        wr_pend;
	logic [31:0] rd_val;
	logic        next_wr_pend;
	logic [31:0] next_csa_val;
	logic [31:0] next_hrdata;
	logic        hit;
	logic [31:0] csa_val;

	// Word decode; only the low address bits take part
	assign hit = i_hsel && i_htrans[ebm_pkg::HTRANS_ACT_BIT] && i_hready
		&& (i_haddr[ebm_pkg::DEC_W-1:2] == ebm_pkg::CSA_OFFSET[ebm_pkg::DEC_W-1:2]);

	// Writes land at the data phase edge; reserved bits never stored
	always_comb begin
		next_wr_pend = hit && i_hwrite;
		next_csa_val = csa_val;
		if (wr_pend) begin
			next_csa_val = i_hwdata & ebm_pkg::CSA_WMASK;
		end
		// Forward a write in flight so back-to-back read sees it
		rd_val      = wr_pend ? next_csa_val : csa_val;
		next_hrdata = (hit && !i_hwrite) ? rd_val : 32'h0000_0000;
	end

	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			wr_pend  <= 1'b0;
			csa_val  <= ebm_pkg::CSA_RESET;
			o_hrdata <= 32'h0000_0000;
		end else begin
			wr_pend  <= next_wr_pend;
			csa_val  <= next_csa_val;
			o_hrdata <= next_hrdata;
		end
	end

	// Zero wait states, always OKAY
	assign o_hreadyout = 1'b1;
	assign o_hresp     = 1'b0;

	assign cfg.cs1_owner_select      = csa_val[ebm_pkg::CS1_OWNER_BIT];
	assign cfg.cs3_nand_logic_enable = csa_val[ebm_pkg::CS3_NAND_BIT];
	assign cfg.cs4_card_slot1_enable = csa_val[ebm_pkg::CS4_CARD1_BIT];
	assign cfg.cs5_card_slot2_enable = csa_val[ebm_pkg::CS5_CARD2_BIT];
	assign cfg.data_pullup_disable   = csa_val[ebm_pkg::DATA_PULLUP_BIT];
	assign cfg.memory_voltage_select = csa_val[ebm_pkg::MEM_VOLT_BIT];
	assign cfg.pad_slew_select       = csa_val[ebm_pkg::PAD_SLEW_BIT];
endmodule

/* design/ebm_pin_mux.sv */
// External memory bus pin multiplexer with chip select assignment
//
// Contract
// - CS1 from static or SDRAM per owner bit
// - CS3 bit enables NAND helper logic
// - CS4 bit enables card slot one logic
// - CS5 bit enables card slot two logic
// - Data pull-ups on unless disable bit set
// - Voltage bit: 0 is 1.8 V, 1 is 3.3 V
// - Assignment register at 0x11C, reset 0x00010000
// - Pins A11..A2 carry SDRAM A9..A0
// - Address-10 pin carries SDRAM A10 only
// - Pins A14..A13 carry SDRAM A12..A11
// - Pins A12, A25..A15 static controller only
// - Pins A1, A0 static controller only
// - Byte-1 strobe: SDRAM mask or static strobe
// - Data lines straight through, same bit order
// - Routing follows controller currently accessing
// - 32-bit data, 26 address, eight selects
// - Strobes active low, clock enable active high
`timescale 1ns/1ps
module ebm_pin_mux (
	input  wire logic                        i_clk,
	input  wire logic                        i_rst_b,
	// AHB-Lite register port
	input  wire logic                        i_hsel,
	input  wire logic [ebm_pkg::HADDR_W-1:0] i_haddr,
	input  wire logic [1:0]                  i_htrans,
	input  wire logic                        i_hwrite,
	input  wire logic [2:0]                  i_hsize,
	input  wire logic [31:0]                 i_hwdata,
	input  wire logic                        i_hready,
	output logic                             o_hreadyout,
	output logic                             o_hresp,
	output logic [31:0]                      o_hrdata,
	// Static memory controller side
	input  wire logic                        i_smc_active,
	input  wire logic [ebm_pkg::ADDR_W-1:0]  i_smc_addr,
	input  wire logic [ebm_pkg::CS_W-1:0]    i_smc_chip_select_n,
	input  wire logic                        i_smc_read_strobe_n,
	input  wire logic                        i_smc_write_enable_n,
	input  wire logic [ebm_pkg::BYTE_W-1:0]  i_smc_byte_write_n,
	input  wire logic [ebm_pkg::DATA_W-1:0]  i_smc_dout,
	input  wire logic                        i_smc_doe,
	output logic                             o_smc_wait_request_n,
	// SDRAM controller side
	input  wire logic                        i_sdc_active,
	input  wire logic [ebm_pkg::SDA_W-1:0]   i_sdc_addr,
	input  wire logic                        i_sdc_chip_select_n,
	input  wire logic                        i_sdc_ras_n,
	input  wire logic                        i_sdc_cas_n,
	input  wire logic                        i_sdc_write_enable_n,
	input  wire logic [ebm_pkg::BANK_W-1:0]  i_sdc_bank,
	input  wire logic                        i_sdc_clock_enable,
	input  wire logic [ebm_pkg::BYTE_W-1:0]  i_sdc_byte_mask_n,
	input  wire logic [ebm_pkg::DATA_W-1:0]  i_sdc_dout,
	input  wire logic                        i_sdc_doe,
	// Read data returned to both controllers
	output logic [ebm_pkg::DATA_W-1:0]       o_ctrl_din,
	// External pins
	input  wire logic [ebm_pkg::DATA_W-1:0]  i_pin_data,
	output logic [ebm_pkg::DATA_W-1:0]       o_pin_data,
	output logic [ebm_pkg::DATA_W-1:0]       o_pin_data_oe,
	output logic [ebm_pkg::ADDR_W-1:0]       o_pin_addr,
	output logic                             o_dram_addr10_pin,
	output logic [ebm_pkg::CS_W-1:0]         o_chip_select_n,
	output logic                             o_read_strobe_n,
	output logic                             o_write_enable_n,
	output logic                             o_byte_strobe1_n,
	output logic                             o_dram_ras_n,
	output logic                             o_dram_cas_n,
	output logic                             o_dram_write_enable_n,
	output logic [ebm_pkg::BANK_W-1:0]       o_dram_bank,
	output logic                             o_dram_clock_enable,
	output logic                             o_nand_select_n,
	output logic                             o_nand_read_n,
	output logic                             o_nand_write_n,
	output logic [1:0]                       o_card_select_n,
	output logic                             o_card_io_read_n,
	output logic                             o_card_io_write_n,
	input  wire logic                        i_wait_request_n,
	// Pad configuration
	output logic                             o_data_pullup_en,
	output logic                             o_memory_voltage_3v3,
	output logic                             o_pad_slew_select
);
	ebm_cfg_if cfg ();

	ebm_pkg::ebm_owner_t owner;

	logic [ebm_pkg::DATA_W-1:0] next_pin_data;
	logic [ebm_pkg::DATA_W-1:0] next_pin_data_oe;
	logic [ebm_pkg::ADDR_W-1:0] next_pin_addr;
	logic                       next_addr10;
	logic [ebm_pkg::CS_W-1:0]   next_cs_n;
	logic                       next_rd_n;
	logic                       next_we_n;
	logic                       next_bs1_n;
	logic                       next_ras_n;
	logic                       next_cas_n;
	logic                       next_sdwe_n;
	logic [ebm_pkg::BANK_W-1:0] next_bank;
	logic                       next_cke;
	logic                       next_nand_cs_n;
	logic                       next_nand_rd_n;
	logic                       next_nand_wr_n;
	logic [1:0]                 next_card_cs_n;
	logic                       next_card_rd_n;
	logic                       next_card_wr_n;
	logic                       next_pullup_en;
	logic                       next_volt_3v3;
	logic                       next_slew;

	// Gate a static strobe by an enabled helper select
	function automatic logic helper_strobe(input logic en,
		input logic cs_n, input logic strobe_n);
		helper_strobe = !(en && !cs_n && !strobe_n);
	endfunction

	// Register block on the AHB-Lite port
	ebm_regs u_regs (
		.i_clk       (i_clk),
		.i_rst_b     (i_rst_b),
		.i_hsel      (i_hsel),
		.i_haddr     (i_haddr),
		.i_htrans    (i_htrans),
		.i_hwrite    (i_hwrite),
		.i_hsize     (i_hsize),
		.i_hwdata    (i_hwdata),
		.i_hready    (i_hready),
		.o_hreadyout (o_hreadyout),
		.o_hresp     (o_hresp),
		.o_hrdata    (o_hrdata),
		.cfg         (cfg.regs)
	);

	// Wait pin is asynchronous; reset high so no false stretch
	ebm_sync #(
		.WIDTH (1),
		.INIT  (1'b1)
	) u_wait_sync (
		.i_clk   (i_clk),
		.i_rst_b (i_rst_b),
		.i_async (i_wait_request_n),
		.o_sync  (o_smc_wait_request_n)
	);

	// Read data from the pins, same order for both controllers
	ebm_sync #(
		.WIDTH (ebm_pkg::DATA_W),
		.INIT  ('0)
	) u_data_sync (
		.i_clk   (i_clk),
		.i_rst_b (i_rst_b),
		.i_async (i_pin_data),
		.o_sync  (o_ctrl_din)
	);

	// Pick the owner of the shared pins for this access.
	// SDRAM wins a collision; its refresh cannot be deferred.
	always_comb begin
		if (i_sdc_active) begin
			owner = ebm_pkg::EBM_OWN_DRAM;
		end else if (i_smc_active) begin
			owner = ebm_pkg::EBM_OWN_STATIC;
		end else begin
			owner = ebm_pkg::EBM_OWN_IDLE;
		end
	end

	// Multiplexed address, data and strobe pins
	always_comb begin
		next_pin_addr    = '0;
		next_addr10      = 1'b0;
		next_pin_data    = '0;
		next_pin_data_oe = '0;
		next_rd_n        = 1'b1;
		next_we_n        = 1'b1;
		next_bs1_n       = 1'b1;
		case (owner)
			ebm_pkg::EBM_OWN_DRAM: begin
				// Pins A0, A1, A12, A15 and up stay low
				next_pin_addr[11:2]  = i_sdc_addr[9:0];
				next_pin_addr[14:13] = i_sdc_addr[12:11];
				next_addr10          = i_sdc_addr[10];
				next_bs1_n           = i_sdc_byte_mask_n[1];
				next_pin_data        = i_sdc_dout;
				next_pin_data_oe     = {ebm_pkg::DATA_W{i_sdc_doe}};
			end
			ebm_pkg::EBM_OWN_STATIC: begin
				next_pin_addr    = i_smc_addr;
				next_rd_n        = i_smc_read_strobe_n;
				next_we_n        = i_smc_write_enable_n;
				next_bs1_n       = i_smc_byte_write_n[1];
				next_pin_data    = i_smc_dout;
				next_pin_data_oe = {ebm_pkg::DATA_W{i_smc_doe}};
			end
			default: begin
				next_pin_addr = '0;
			end
		endcase
	end

	// Chip selects and helper strobes
	always_comb begin
		next_cs_n = i_smc_chip_select_n;
		if (cfg.cs1_owner_select) begin
			next_cs_n[ebm_pkg::CS_OWNED_IDX] = i_sdc_chip_select_n;
		end
		// NAND helper only when enabled; otherwise NAND select held high
		next_nand_cs_n = cfg.cs3_nand_logic_enable
			? i_smc_chip_select_n[ebm_pkg::CS_NAND_IDX] : 1'b1;
		next_nand_rd_n = helper_strobe(cfg.cs3_nand_logic_enable,
			i_smc_chip_select_n[ebm_pkg::CS_NAND_IDX],
			i_smc_read_strobe_n);
		next_nand_wr_n = helper_strobe(cfg.cs3_nand_logic_enable,
			i_smc_chip_select_n[ebm_pkg::CS_NAND_IDX],
			i_smc_write_enable_n);
		next_card_cs_n[0] = cfg.cs4_card_slot1_enable
			? i_smc_chip_select_n[ebm_pkg::CS_CARD1_IDX] : 1'b1;
		next_card_cs_n[1] = cfg.cs5_card_slot2_enable
			? i_smc_chip_select_n[ebm_pkg::CS_CARD2_IDX] : 1'b1;
		next_card_rd_n = helper_strobe(cfg.cs4_card_slot1_enable,
			i_smc_chip_select_n[ebm_pkg::CS_CARD1_IDX],
			i_smc_read_strobe_n)
			& helper_strobe(cfg.cs5_card_slot2_enable,
			i_smc_chip_select_n[ebm_pkg::CS_CARD2_IDX],
			i_smc_read_strobe_n);
		next_card_wr_n = helper_strobe(cfg.cs4_card_slot1_enable,
			i_smc_chip_select_n[ebm_pkg::CS_CARD1_IDX],
			i_smc_write_enable_n)
			& helper_strobe(cfg.cs5_card_slot2_enable,
			i_smc_chip_select_n[ebm_pkg::CS_CARD2_IDX],
			i_smc_write_enable_n);
	end

	// Dedicated SDRAM pins and pad configuration
	always_comb begin
		next_ras_n     = i_sdc_ras_n;
		next_cas_n     = i_sdc_cas_n;
		next_sdwe_n    = i_sdc_write_enable_n;
		next_bank      = i_sdc_bank;
		next_cke       = i_sdc_clock_enable;
		next_pullup_en = !cfg.data_pullup_disable;
		next_volt_3v3  = cfg.memory_voltage_select;
		next_slew      = cfg.pad_slew_select;
	end

	// Every pin output leaves from a flip-flop; reset is idle
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_pin_addr            <= '0;
			o_dram_addr10_pin     <= 1'b0;
			o_pin_data            <= '0;
			o_pin_data_oe         <= '0;
			o_chip_select_n       <= '1;
			o_read_strobe_n       <= 1'b1;
			o_write_enable_n      <= 1'b1;
			o_byte_strobe1_n      <= 1'b1;
			o_dram_ras_n          <= 1'b1;
			o_dram_cas_n          <= 1'b1;
			o_dram_write_enable_n <= 1'b1;
			o_dram_bank           <= '0;
			o_dram_clock_enable   <= 1'b0;
			o_nand_select_n       <= 1'b1;
			o_nand_read_n         <= 1'b1;
			o_nand_write_n        <= 1'b1;
			o_card_select_n       <= 2'h3;
			o_card_io_read_n      <= 1'b1;
			o_card_io_write_n     <= 1'b1;
			o_data_pullup_en      <= 1'b1;
			o_memory_voltage_3v3  <= 1'b1;
			o_pad_slew_select     <= 1'b0;
		end else begin
			o_pin_addr            <= next_pin_addr;
			o_dram_addr10_pin     <= next_addr10;
			o_pin_data            <= next_pin_data;
			o_pin_data_oe         <= next_pin_data_oe;
			o_chip_select_n       <= next_cs_n;
			o_read_strobe_n       <= next_rd_n;
			o_write_enable_n      <= next_we_n;
			o_byte_strobe1_n      <= next_bs1_n;
			o_dram_ras_n          <= next_ras_n;
			o_dram_cas_n          <= next_cas_n;
			o_dram_write_enable_n <= next_sdwe_n;
			o_dram_bank           <= next_bank;
			o_dram_clock_enable   <= next_cke;
			o_nand_select_n       <= next_nand_cs_n;
			o_nand_read_n         <= next_nand_rd_n;
			o_nand_write_n        <= next_nand_wr_n;
			o_card_select_n       <= next_card_cs_n;
			o_card_io_read_n      <= next_card_rd_n;
			o_card_io_write_n     <= next_card_wr_n;
			o_data_pullup_en      <= next_pullup_en;
			o_memory_voltage_3v3  <= next_volt_3v3;
			o_pad_slew_select     <= next_slew;
		end
	end
endmodule

/* verification/ebm_pin_mux_asserts.sv */
// Port-level assertions for the external memory bus pin mux
`timescale 1ns/1ps
module ebm_pin_mux_asserts (
	input wire logic        i_clk,
	input wire logic        i_rst_b,
	input wire logic        i_hsel,
	input wire logic [31:0] i_haddr,
	input wire logic [1:0]  i_htrans,
	input wire logic        i_hwrite,
	input wire logic [31:0] i_hwdata,
	input wire logic [31:0] o_hrdata,
	input wire logic        i_smc_active,
	input wire logic [25:0] i_smc_addr,
	input wire logic [7:0]  i_smc_chip_select_n,
	input wire logic [3:0]  i_smc_byte_write_n,
	input wire logic        i_sdc_active,
	input wire logic [12:0] i_sdc_addr,
	input wire logic        i_sdc_chip_select_n,
	input wire logic [3:0]  i_sdc_byte_mask_n,
	input wire logic [31:0] i_pin_data,
	input wire logic [31:0] o_ctrl_din,
	input wire logic [25:0] o_pin_addr,
	input wire logic        o_dram_addr10_pin,
	input wire logic [7:0]  o_chip_select_n,
	input wire logic        o_byte_strobe1_n,
	input wire logic        o_nand_select_n,
	input wire logic        o_data_pullup_en,
	input wire logic        o_memory_voltage_3v3,
	input wire logic        o_pad_slew_select
);
	logic        wr_pend;
	logic [31:0] shadow;
	logic        rd_take;

	// Shadow register, updated at the write's data-phase edge
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			wr_pend <= 1'b0;
			shadow  <= 32'h0001_0000;
		end else begin
			wr_pend <= i_hsel && i_htrans[1] && i_hwrite
				&& i_haddr[11:0] == 12'h11C;
			if (wr_pend)
				shadow <= i_hwdata & 32'h0003_013A;
		end
	end
	assign rd_take = i_hsel && i_htrans[1] && !i_hwrite;

	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rst_b);

	a_sdram_addr: assert property (
		i_sdc_active |=> o_pin_addr[11:2] == $past(i_sdc_addr[9:0])
			&& o_pin_addr[14:13] == $past(i_sdc_addr[12:11]))
		else $error("SDRAM address bits misrouted");
	a_addr10_pin: assert property (
		1'b1 |=> o_dram_addr10_pin
			== ($past(i_sdc_active) && $past(i_sdc_addr[10])))
		else $error("Address-10 pin wrong");
	a_static_addr: assert property (
		i_smc_active && !i_sdc_active |=> o_pin_addr == $past(i_smc_addr))
		else $error("Static address not passed");
	a_strobe_one: assert property (
		1'b1 |=> o_byte_strobe1_n == ($past(i_sdc_active)
			? $past(i_sdc_byte_mask_n[1]) : !$past(i_smc_active)
			|| $past(i_smc_byte_write_n[1])))
		else $error("Byte-1 strobe wrong");
	a_cs1_owner: assert property (
		1'b1 |=> o_chip_select_n[1] == ($past(shadow[1])
			? $past(i_sdc_chip_select_n) : $past(i_smc_chip_select_n[1])))
		else $error("Select 1 from wrong controller");
	a_nand_gate: assert property (
		1'b1 |=> o_nand_select_n
			== (!$past(shadow[3]) || $past(i_smc_chip_select_n[3])))
		else $error("NAND select gating wrong");
	a_pad_config: assert property (
		1'b1 |=> o_data_pullup_en == !$past(shadow[8])
			&& o_memory_voltage_3v3 == $past(shadow[16])
			&& o_pad_slew_select == $past(shadow[17]))
		else $error("Pad configuration wrong");
	a_read_data: assert property (
		rd_take |=> o_hrdata == ($past(i_haddr[11:0]) == 12'h11C
			? shadow : 32'h0))
		else $error("Read data wrong");
	a_data_return: assert property (
		$past(i_rst_b) |=> ##1 o_ctrl_din == $past(i_pin_data, 2))
		else $error("Returned data wrong");

	// Main scenarios reached
	c_sdram_wins: cover property (i_sdc_active && i_smc_active);
	c_reg_write: cover property (wr_pend);
	c_reg_read: cover property (rd_take);
endmodule

/* verification/ebm_ext_dev.sv */
// Behavioural external memories on the data bus and the wait pin
`timescale 1ns/1ps
module ebm_ext_dev #(
	parameter logic [31:0] RD_WORD = 32'hA5C3_1E96
) (
	input  wire logic       i_clk,
	input  wire logic [7:0] i_chip_select_n,
	input  wire logic       i_read_strobe_n,
	input  wire logic       i_pullup_en,
	input  wire logic       i_stall,
	output logic [31:0]     o_data,
	output logic            o_wait_request_n
);
	logic [15:0] churn = 16'h5A3C;

	// Released lines not pulled up flip every cycle so a stale value never passes
	always @(posedge i_clk)
		churn <= ~churn;

	// Selected device drives on a read; low half follows the pull-ups
	always_comb begin
		if (!i_read_strobe_n && !(&i_chip_select_n))
			o_data = RD_WORD;
		else
			o_data = {churn, i_pullup_en ? 16'hFFFF : churn};
	end

	// Stretch only while the bench asks for it
	assign o_wait_request_n = !i_stall;
endmodule

/* verification/ebm_pin_mux_test.sv */
// Self-checking bench for the external memory bus pin mux
`timescale 1ns/1ps
module ebm_pin_mux_test;
	logic        i_clk = 1'b0, i_rst_b, i_hsel, i_hwrite, stall;
	logic        i_smc_active, i_smc_read_strobe_n, i_smc_write_enable_n;
	logic        i_smc_doe, i_sdc_active, i_sdc_chip_select_n, i_sdc_doe;
	logic        i_sdc_ras_n, i_sdc_cas_n, i_sdc_write_enable_n;
	logic        i_sdc_clock_enable, i_hready, i_wait_request_n;
	logic        o_hreadyout, o_hresp, o_smc_wait_request_n;
	logic        o_dram_addr10_pin, o_read_strobe_n, o_write_enable_n;
	logic        o_byte_strobe1_n, o_dram_ras_n, o_dram_cas_n;
	logic        o_dram_write_enable_n, o_dram_clock_enable, o_nand_select_n;
	logic        o_nand_read_n, o_nand_write_n, o_card_io_read_n;
	logic        o_card_io_write_n, o_data_pullup_en, o_memory_voltage_3v3;
	logic        o_pad_slew_select;
	logic [1:0]  i_htrans, i_sdc_bank, o_dram_bank, o_card_select_n;
	logic [2:0]  i_hsize;
	logic [3:0]  i_smc_byte_write_n, i_sdc_byte_mask_n;
	logic [7:0]  i_smc_chip_select_n, o_chip_select_n;
	logic [12:0] i_sdc_addr;
	logic [25:0] i_smc_addr, o_pin_addr;
	logic [31:0] i_haddr, i_hwdata, o_hrdata, i_smc_dout, i_sdc_dout;
	logic [31:0] o_ctrl_din, i_pin_data, o_pin_data, o_pin_data_oe, dev_data;
	int          num_errors = 0;
	int          checks = 0;

	// Ready loops back; each data line resolves from whoever drives it
	assign i_hready = o_hreadyout;
	assign i_pin_data = (o_pin_data & o_pin_data_oe)
		| (dev_data & ~o_pin_data_oe);

	ebm_pin_mux dut (.*);
	ebm_ext_dev ext (
		.i_clk           (i_clk),
		.i_chip_select_n (o_chip_select_n),
		.i_read_strobe_n (o_read_strobe_n),
		.i_pullup_en     (o_data_pullup_en),
		.i_stall         (stall),
		.o_data          (dev_data),
		.o_wait_request_n(i_wait_request_n)
	);

	always #12.5 i_clk = ~i_clk;

	task automatic chk(input logic [31:0] got, input logic [31:0] exp,
			input string what);
		checks++;
		if (got !== exp) begin
			num_errors++;
			$display("CHECK FAILED at %0t: %s got %h expected %h",
				$time, what, got, exp);
		end
	endtask

	task automatic step;
		@(posedge i_clk);
		#1;
	endtask

	// One single transfer; entered just after a rising edge
	task automatic bus(input logic w, input logic [31:0] a,
			input logic [31:0] wd, output logic [31:0] rd);
		i_hsel   <= 1'b1;
		i_htrans <= 2'h2;
		i_haddr  <= a;
		i_hwrite <= w;
		do @(posedge i_clk); while (i_hready !== 1'b1);
		i_htrans <= 2'h0;
		i_hwdata <= wd;
		do @(posedge i_clk); while (i_hready !== 1'b1);
		rd = o_hrdata;
	endtask

	task automatic t_regs;
		logic [31:0] v;
		@(posedge i_clk);
		bus(1'b0, 32'h11C, 32'h0, v);
		chk(v, 32'h0001_0000, "reset value");
		chk({o_hreadyout, o_hresp}, 2'h2, "okay");
		chk({o_data_pullup_en, o_memory_voltage_3v3, o_pad_slew_select},
			3'h6, "pads");
		bus(1'b1, 32'h11C, 32'hFFFF_FFFF, v);
		bus(1'b1, 32'h120, 32'h0, v);
		bus(1'b0, 32'h11C, 32'h0, v);
		chk(v, 32'h0003_013A, "field mask");
		chk({o_data_pullup_en, o_memory_voltage_3v3, o_pad_slew_select},
			3'h3, "pads");
		bus(1'b1, 32'h11C, 32'h0, v);
		bus(1'b0, 32'h120, 32'h0, v);
		chk(v, 32'h0, "unmapped read");
		chk({o_data_pullup_en, o_memory_voltage_3v3, o_pad_slew_select},
			3'h4, "pads");
		$display("t_regs done");
	endtask

	// SDRAM wins the shared pins even with a static request pending
	task automatic t_sdram;
		logic [12:0] a;
		logic [31:0] e;
		@(posedge i_clk);
		{i_sdc_ras_n, i_sdc_write_enable_n} <= 2'h0;
		{i_sdc_bank, i_sdc_clock_enable} <= 3'h5;
		for (int k = 0; k < 2; k++) begin
			a = k ? 13'h05A4 : 13'h1A5B;
			@(posedge i_clk);
			{i_sdc_active, i_smc_active, i_sdc_doe} <= 3'h7;
			i_smc_addr <= 26'h3FF_FFFF;
			i_sdc_addr <= a;
			i_sdc_dout <= {a, 19'h2A5F3};
			i_sdc_byte_mask_n <= {2'h3, k[0], 1'b1};
			step;
			e = {6'h0, 11'h0, a[12:11], 1'b0, a[9:0], 2'h0};
			chk(o_pin_addr, e, "sdram addr");
			chk(o_dram_addr10_pin, a[10], "addr10");
			chk(o_byte_strobe1_n, k[0], "byte1");
			chk(o_pin_data & o_pin_data_oe, {a, 19'h2A5F3}, "data");
		end
		e = {26'h0, o_dram_ras_n, o_dram_cas_n, o_dram_write_enable_n,
			o_dram_bank, o_dram_clock_enable};
		chk(e, 32'h15, "dram control");
		$display("t_sdram done");
	endtask

	// Static read returns device data two edges later, then idle pins
	task automatic t_static;
		@(posedge i_clk);
		{i_sdc_active, i_sdc_doe, i_smc_read_strobe_n} <= 3'h0;
		i_smc_addr <= 26'h2AB_CDEF;
		i_smc_chip_select_n <= 8'hFE;
		i_smc_byte_write_n <= 4'hD;
		step;
		chk(o_pin_addr, 26'h2AB_CDEF, "static addr");
		chk({o_dram_addr10_pin, o_byte_strobe1_n}, 2'h0, "a10 b1");
		repeat (2) @(posedge i_clk);
		#1;
		chk(o_ctrl_din, 32'hA5C3_1E96, "read data");
		@(posedge i_clk);
		i_smc_active <= 1'b0;
		step;
		chk(o_pin_data_oe | 32'(o_pin_addr), 32'h0, "idle pins");
		chk({o_read_strobe_n, o_write_enable_n, o_byte_strobe1_n}, 3'h7,
			"idle strobes");
		$display("t_static done");
	endtask

	// Assignment bits move select 1 and gate the helper selects
	task automatic t_chipsel;
		logic [31:0] v;
		@(posedge i_clk);
		i_smc_chip_select_n <= 8'h00;
		for (int k = 1; k >= 0; k--) begin
			bus(1'b1, 32'h11C, k ? 32'h3A : 32'h0, v);
			step;
			chk(o_chip_select_n, k ? 8'h02 : 8'h00, "selects");
			v = {o_nand_select_n, o_nand_read_n, o_card_select_n,
				o_card_io_read_n};
			chk(v, k ? 32'h0 : 32'h1F, "helpers");
			@(posedge i_clk);
		end
		$display("t_chipsel done");
	endtask

	// A stretch request reaches the static controller after two edges
	task automatic t_wait;
		for (int k = 0; k < 2; k++) begin
			@(posedge i_clk);
			stall <= !k[0];
			repeat (2) @(posedge i_clk);
			#1;
			chk(o_smc_wait_request_n, k[0], "wait");
		end
		$display("t_wait done");
	endtask

	task automatic summarize;
		$display("Counts: %0d checks, %0d mismatches", checks, num_errors);
		if (num_errors == 0 && checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	initial begin
		{i_hsel, i_hwrite, stall, i_smc_active, i_smc_doe, i_sdc_active,
			i_sdc_doe, i_sdc_clock_enable, i_htrans, i_sdc_bank, i_haddr,
			i_hwdata, i_smc_addr, i_sdc_addr, i_smc_dout, i_sdc_dout} = '0;
		{i_smc_read_strobe_n, i_smc_write_enable_n, i_sdc_chip_select_n,
			i_sdc_ras_n, i_sdc_cas_n, i_sdc_write_enable_n,
			i_smc_byte_write_n, i_sdc_byte_mask_n, i_smc_chip_select_n} = '1;
		i_hsize = 3'h2;
		i_rst_b = 1'b0;
		repeat (6) @(posedge i_clk);
		i_rst_b <= 1'b1;
		t_regs();
		t_sdram();
		t_static();
		t_chipsel();
		t_wait();
		summarize();
	end

	// Whole run needs under fifty cycles; this cuts a hang short
	initial begin
		repeat (2000) @(posedge i_clk);
		num_errors++;
		summarize();
	end
endmodule

bind ebm_pin_mux ebm_pin_mux_asserts u_chk (.*);
